// ### logic/lockup_pkg.sv
// Constants, register map and carrier types for the fault lockup controller.
// Assumes a single 125 MHz clock and an asynchronous active-high reset.
package lockup_pkg;

  // Clock and time base
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned ALARM_MIN_MS = 1500;
  localparam logic [15:0] ALARM_MIN_TICKS = 16'(ALARM_MIN_MS / TICK_MS);

  // Register byte offsets
  localparam logic [5:0] REG_CTRL = 6'h00;
  localparam logic [5:0] REG_DIVERT_LIMIT = 6'h04;
  localparam logic [5:0] REG_HOPPER_TIMEOUT = 6'h08;
  localparam logic [5:0] REG_JAM_TIME = 6'h0C;
  localparam logic [5:0] REG_TICKET_LIMIT = 6'h10;
  localparam logic [5:0] REG_FAULT_STATUS = 6'h14;
  localparam logic [5:0] REG_MISROUTE_COUNT = 6'h18;

  // Control field positions
  localparam int unsigned CTRL_PAPER_OUT_FITTED = 0;
  localparam int unsigned CTRL_RESUME_FROM_START = 1;

  // Reset values
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] DIVERT_LIMIT_RESET = 8'h0A;
  localparam logic [15:0] HOPPER_TIMEOUT_RESET = 16'h07D0;
  localparam logic [15:0] JAM_TIME_RESET = 16'h01F4;
  localparam logic [7:0] TICKET_LIMIT_RESET = 8'h05;

  // Fault flag positions
  localparam int unsigned NUM_FAULTS = 10;
  localparam int unsigned F_COIN_REVERSAL = 0;
  localparam int unsigned F_DIVERTER = 1;
  localparam int unsigned F_HOPPER_EMPTY = 2;
  localparam int unsigned F_HOPPER_JAM = 3;
  localparam int unsigned F_EXTRA_COIN = 4;
  localparam int unsigned F_RUNAWAY = 5;
  localparam int unsigned F_REEL_STALL = 6;
  localparam int unsigned F_REEL_ILLEGAL = 7;
  localparam int unsigned F_PERIPHERAL = 8;
  localparam int unsigned F_PAPER_LOW = 9;

  // Lockup sequence, Gray coded along RUN-SAVE-LOCKED-RESUME
  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_SAVE = 2'h1,
    ST_LOCKED = 2'h3,
    ST_RESUME = 2'h2
  } lock_state_t;

  typedef struct packed {
    logic motor_off;
    logic brake;
  } hopper_cmd_t;

endpackage

// ### logic/fault_flags.sv
// Bank of sticky fault flags; a set in the same cycle as a clear wins.
// Assumes set and clear are single-cycle or level requests on clk_i.
`timescale 1ns/1ns
`default_nettype none
module fault_flags #(
  parameter int unsigned N = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [N-1:0] set_i,
  input wire logic [N-1:0] clr_i,
  output logic [N-1:0] flags_o
);

  typedef struct packed {
    logic [N-1:0] flags;
  } flag_state_t;

  flag_state_t st;
  flag_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.flags = set_i | (st.flags & ~clr_i);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign flags_o = st.flags;

endmodule
`default_nettype wire

// ### logic/interval_counter.sv
// Counts tick enables while run_i is high; restarts from zero when it drops.
// Assumes tick_i is a one-cycle enable from a divider on the same clock.
`timescale 1ns/1ns
`default_nettype none
module interval_counter #(
  parameter int unsigned W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [W-1:0] limit_i,
  output logic done_o
);

  typedef struct packed {
    logic [W-1:0] count;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;

  always_comb begin
    next_st = st;
    if (!run_i) begin
      next_st.count = '0;
    end else if (tick_i && st.count < limit_i) begin
      next_st.count = st.count + W'(1);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done_o = run_i && (st.count >= limit_i);

endmodule
`default_nettype wire

// ### logic/machine_fault_lockup_controller.sv
// Fault lockup controller: latches machine faults, locks the machine and restores it.
// Assumes sensor inputs are synchronous to clk_i and event inputs are one-cycle pulses.
//
// Functional notes
// - Any latched fault raises the fault message display request.
// - During a fault all player inputs except service are disabled.
// - Alarm turns on at fault entry and stays on at least 1.5 s.
// - Fault entry requests saving the incomplete game before locking.
// - Fault entry commands all reels to stop at once.
// - Payout in progress at fault: hopper motor off, brake applied.
// - Clearing all faults withdraws the fault message request.
// - Clearing re-enables player inputs allowed by the machine state.
// - Clearing turns the alarm off once its minimum time is met.
// - Clearing signals game resume, from start or interruption point.
// - A coin moving backwards is detected as a coin reversal.
// - A single reversal is only an information event.
// - Consecutive reversals raise a fault cleared by attendant key.
// - Misdirected coins reaching the limit raise a diverter fault.
// - Misroute count resets at power-up; fault clears when rectified.
// - No hopper coin within timeout during payout raises hopper empty.
// - Hopper output sensor staying blocked raises hopper jam.
// - One coin after payout completes raises extra coin fault.
// - Several coins after payout raise run-away; door sequence clears hopper.
// - Reel stall or illegal movement faults clear on door open/close.
// - Peripheral failure fault clears only by technician action.
// - Paper low locks after a preset number of further tickets.
// - With paper-out sensor fitted, paper low only raises a message.
`timescale 1ns/1ns
`default_nettype none
module machine_fault_lockup_controller
  import lockup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned PLAYER_INPUTS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Avalon-MM slave
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Coin path
  input wire logic coin_reversal_i,
  input wire logic coin_good_i,
  input wire logic coin_routed_i,
  input wire logic coin_misrouted_i,
  // Hopper
  input wire logic payout_active_i,
  input wire logic hopper_coin_i,
  input wire logic hopper_blocked_i,
  // Reels and peripherals
  input wire logic reel_stall_i,
  input wire logic reel_illegal_i,
  input wire logic periph_fail_i,
  // Printer
  input wire logic paper_low_i,
  input wire logic ticket_printed_i,
  // Clear actions
  input wire logic attendant_key_i,
  input wire logic door_open_i,
  input wire logic tech_clear_i,
  // Game and player side
  input wire logic game_saved_i,
  input wire logic [PLAYER_INPUTS-1:0] player_allowed_i,
  input wire logic service_button_i,
  output logic [PLAYER_INPUTS-1:0] player_en_o,
  output logic coin_accept_en_o,
  output logic service_o,
  output logic fault_msg_o,
  output logic info_msg_o,
  output logic paper_low_msg_o,
  output logic alarm_o,
  output logic game_save_o,
  output logic game_resume_o,
  output logic resume_from_start_o,
  output logic reel_stop_o,
  output hopper_cmd_t hopper_o,
  output logic lockup_o,
  output logic [NUM_FAULTS-1:0] fault_flags_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    lock_state_t state;
    logic [31:0] tick_div;
    logic tick;
    logic ack;
    logic [31:0] rdata;
    logic [1:0] ctrl;
    logic [7:0] divert_limit;
    logic [15:0] hopper_timeout;
    logic [15:0] jam_time;
    logic [7:0] ticket_limit;
    logic reversal_pending;
    logic info;
    logic [7:0] misroute_count;
    logic payout_prev;
    logic post_payout;
    logic [1:0] post_coins;
    logic door_prev;
    logic [7:0] tickets_since_low;
    logic alarm_on;
    logic hopper_halt;
    logic msg;
    logic reel_stop;
    logic save;
    logic resume;
    logic [PLAYER_INPUTS-1:0] player_en;
    logic coin_en;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  logic [NUM_FAULTS-1:0] flags;
  logic [NUM_FAULTS-1:0] fault_set;
  logic [NUM_FAULTS-1:0] fault_clr;
  logic any_fault;
  logic alarm_done;
  logic empty_done;
  logic jam_done;
  logic door_closed_edge;
  logic diverter_cond;
  logic paper_lock_cond;
  logic req;
  logic [31:0] wmask;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-blocks
  // latched flags
  fault_flags #(
    .N(NUM_FAULTS)
  ) u_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .set_i(fault_set),
    .clr_i(fault_clr),
    .flags_o(flags)
  );

  interval_counter #(
    .W(16)
  ) u_alarm_min (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st.alarm_on),
    .tick_i(st.tick),
    .limit_i(ALARM_MIN_TICKS),
    .done_o(alarm_done)
  );

  interval_counter #(
    .W(16)
  ) u_hopper_empty (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(payout_active_i && !hopper_coin_i),
    .tick_i(st.tick),
    .limit_i(st.hopper_timeout),
    .done_o(empty_done)
  );

  interval_counter #(
    .W(16)
  ) u_hopper_jam (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(hopper_blocked_i),
    .tick_i(st.tick),
    .limit_i(st.jam_time),
    .done_o(jam_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault detection and clearing
  assign any_fault = |flags;
  assign door_closed_edge = st.door_prev && !door_open_i;
  assign diverter_cond = (st.misroute_count >= st.divert_limit);
  assign paper_lock_cond = paper_low_i && !st.ctrl[CTRL_PAPER_OUT_FITTED]
                           && (st.tickets_since_low >= st.ticket_limit);

  always_comb begin
    fault_set = '0;
    fault_clr = '0;
    fault_set[F_COIN_REVERSAL] = coin_reversal_i && st.reversal_pending;
    fault_clr[F_COIN_REVERSAL] = attendant_key_i;
    fault_set[F_DIVERTER] = diverter_cond;
    fault_clr[F_DIVERTER] = !diverter_cond;
    fault_set[F_HOPPER_EMPTY] = empty_done;
    fault_set[F_HOPPER_JAM] = jam_done;
    fault_set[F_EXTRA_COIN] = st.post_payout && hopper_coin_i && (st.post_coins == 2'h0);
    fault_set[F_RUNAWAY] = st.post_payout && hopper_coin_i && (st.post_coins != 2'h0);
    fault_clr[F_HOPPER_EMPTY] = door_closed_edge;
    fault_clr[F_HOPPER_JAM] = door_closed_edge;
    fault_clr[F_EXTRA_COIN] = door_closed_edge;
    fault_clr[F_RUNAWAY] = door_closed_edge;
    fault_set[F_REEL_STALL] = reel_stall_i;
    fault_set[F_REEL_ILLEGAL] = reel_illegal_i;
    fault_clr[F_REEL_STALL] = door_closed_edge;
    fault_clr[F_REEL_ILLEGAL] = door_closed_edge;
    fault_set[F_PERIPHERAL] = periph_fail_i;
    fault_clr[F_PERIPHERAL] = tech_clear_i;
    fault_set[F_PAPER_LOW] = paper_lock_cond;
    fault_clr[F_PAPER_LOW] = !paper_low_i || attendant_key_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  assign req = avs_read || avs_write;
  assign avs_waitrequest = req && !st.ack;
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_st = st;
    // Millisecond tick divider
    next_st.tick = 1'b0;
    if (st.tick_div >= TICK_CYCLES - 1) begin
      next_st.tick_div = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_div = st.tick_div + 32'h1;
    end

    // Bus: answer in the cycle after the request is seen
    next_st.ack = req && !st.ack;
    if (req && !st.ack && avs_read) begin
      case (avs_address)
        REG_CTRL: next_st.rdata = {30'h0, st.ctrl};
        REG_DIVERT_LIMIT: next_st.rdata = {24'h0, st.divert_limit};
        REG_HOPPER_TIMEOUT: next_st.rdata = {16'h0, st.hopper_timeout};
        REG_JAM_TIME: next_st.rdata = {16'h0, st.jam_time};
        REG_TICKET_LIMIT: next_st.rdata = {24'h0, st.ticket_limit};
        REG_FAULT_STATUS: next_st.rdata = {16'h0, st.state, st.alarm_on, any_fault, 2'h0, flags};
        REG_MISROUTE_COUNT: next_st.rdata = {24'h0, st.misroute_count};
        default: next_st.rdata = 32'h0;
      endcase
    end
    if (avs_write && st.ack) begin
      case (avs_address)
        REG_CTRL: next_st.ctrl = (st.ctrl & ~wmask[1:0]) | (avs_writedata[1:0] & wmask[1:0]);
        REG_DIVERT_LIMIT: next_st.divert_limit = (st.divert_limit & ~wmask[7:0])
                                                 | (avs_writedata[7:0] & wmask[7:0]);
        REG_HOPPER_TIMEOUT: next_st.hopper_timeout = (st.hopper_timeout & ~wmask[15:0])
                                                     | (avs_writedata[15:0] & wmask[15:0]);
        REG_JAM_TIME: next_st.jam_time = (st.jam_time & ~wmask[15:0])
                                         | (avs_writedata[15:0] & wmask[15:0]);
        REG_TICKET_LIMIT: next_st.ticket_limit = (st.ticket_limit & ~wmask[7:0])
                                                 | (avs_writedata[7:0] & wmask[7:0]);
        default: next_st.ctrl = st.ctrl;
      endcase
    end

    next_st.info = coin_reversal_i && !st.reversal_pending;
    if (coin_reversal_i) begin
      next_st.reversal_pending = 1'b1;
    end else if (coin_good_i) begin
      next_st.reversal_pending = 1'b0;
    end

    if (coin_misrouted_i && st.misroute_count != 8'hFF) begin
      next_st.misroute_count = st.misroute_count + 8'h1;
    end else if (coin_routed_i) begin
      next_st.misroute_count = 8'h0;
    end

    next_st.payout_prev = payout_active_i;
    if (payout_active_i) begin
      next_st.post_payout = 1'b0;
      next_st.post_coins = 2'h0;
    end else if (st.payout_prev) begin
      next_st.post_payout = 1'b1;
    end else if (st.post_payout && hopper_coin_i && st.post_coins != 2'h3) begin
      next_st.post_coins = st.post_coins + 2'h1;
    end

    next_st.door_prev = door_open_i;

    if (!paper_low_i) begin
      next_st.tickets_since_low = 8'h0;
    end else if (ticket_printed_i && st.tickets_since_low != 8'hFF) begin
      next_st.tickets_since_low = st.tickets_since_low + 8'h1;
    end

    // Lockup sequence
    next_st.save = 1'b0;
    next_st.resume = 1'b0;
    case (st.state)
      ST_RUN: begin
        if (any_fault) begin
          next_st.state = ST_SAVE;
          next_st.alarm_on = 1'b1;
          next_st.hopper_halt = payout_active_i;
          next_st.save = 1'b1;
        end
      end
      ST_SAVE: begin
        next_st.save = !game_saved_i;
        if (game_saved_i) begin
          next_st.state = ST_LOCKED;
        end
      end
      ST_LOCKED: begin
        if (!any_fault) begin
          next_st.state = ST_RESUME;
        end
      end
      ST_RESUME: begin
        next_st.resume = 1'b1;
        next_st.hopper_halt = 1'b0;
        next_st.state = ST_RUN;
      end
      default: begin
        next_st.state = ST_RUN;
      end
    endcase

    // alarm off after clear and minimum time
    if (st.alarm_on && alarm_done && st.state == ST_RUN && !any_fault) begin
      next_st.alarm_on = 1'b0;
    end

    next_st.msg = any_fault || (next_st.state != ST_RUN);
    next_st.reel_stop = next_st.msg;
    next_st.player_en = next_st.msg ? '0 : player_allowed_i;
    next_st.coin_en = !next_st.msg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
      st.state <= ST_RUN;
      st.ctrl <= CTRL_RESET;
      st.divert_limit <= DIVERT_LIMIT_RESET;
      st.hopper_timeout <= HOPPER_TIMEOUT_RESET;
      st.jam_time <= JAM_TIME_RESET;
      st.ticket_limit <= TICKET_LIMIT_RESET;
      st.coin_en <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign avs_readdata = st.rdata;
  assign player_en_o = st.player_en;
  assign coin_accept_en_o = st.coin_en;
  assign service_o = service_button_i;
  assign fault_msg_o = st.msg;
  assign info_msg_o = st.info;
  assign paper_low_msg_o = paper_low_i && st.ctrl[CTRL_PAPER_OUT_FITTED];
  assign alarm_o = st.alarm_on;
  assign game_save_o = st.save;
  assign game_resume_o = st.resume;
  assign resume_from_start_o = st.ctrl[CTRL_RESUME_FROM_START];
  assign reel_stop_o = st.reel_stop;
  assign hopper_o.motor_off = st.hopper_halt;
  assign hopper_o.brake = st.hopper_halt;
  assign lockup_o = st.msg;
  assign fault_flags_o = flags;

endmodule
`default_nettype wire

// ### test/lockup_monitor.sv
// Checker for the fault lockup controller, bound to its top ports.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module lockup_monitor
  import lockup_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF,
  parameter int unsigned PLAYER_INPUTS = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic payout_active_i,
  input wire logic attendant_key_i,
  input wire logic tech_clear_i,
  input wire logic service_button_i,
  input wire logic [PLAYER_INPUTS-1:0] player_en_o,
  input wire logic coin_accept_en_o,
  input wire logic service_o,
  input wire logic fault_msg_o,
  input wire logic alarm_o,
  input wire logic game_save_o,
  input wire logic game_resume_o,
  input wire logic reel_stop_o,
  input wire hopper_cmd_t hopper_o,
  input wire logic lockup_o,
  input wire logic [NUM_FAULTS-1:0] fault_flags_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  localparam int unsigned MIN_ON = (ALARM_MIN_MS / TICK_MS - 1) * TICK_CYCLES;
  logic [31:0] on_cnt;
  ////////////////////////////////////////
  // Cycles the alarm has stood on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      on_cnt <= '0;
    end else begin
      on_cnt <= alarm_o ? on_cnt + 32'h1 : '0;
    end
  end
  sequence s_entry; $rose(lockup_o); endsequence
  sequence s_exit; $fell(lockup_o); endsequence
  property p_entry; $rose(|fault_flags_o) |=> lockup_o; endproperty
  a_entry: assert property (p_entry) else $error("no lockup after fault");
  property p_hold; (|fault_flags_o) [*2] |=> lockup_o; endproperty
  a_hold: assert property (p_hold) else $error("lockup dropped with flag set");
  property p_inputs; lockup_o |-> player_en_o == '0 && !coin_accept_en_o; endproperty
  a_inputs: assert property (p_inputs) else $error("inputs live while locked");
  property p_service; service_o == service_button_i; endproperty
  a_service: assert property (p_service) else $error("service button blocked");
  property p_alarm; s_entry |-> alarm_o && game_save_o; endproperty
  a_alarm: assert property (p_alarm) else $error("alarm or save missing");
  property p_alarm_min; $fell(alarm_o) |-> on_cnt >= MIN_ON; endproperty
  a_alarm_min: assert property (p_alarm_min) else $error("alarm too short");
  property p_reel; reel_stop_o == fault_msg_o && lockup_o == fault_msg_o; endproperty
  a_reel: assert property (p_reel) else $error("reel stop mismatch");
  property p_hopper; s_entry and $past(payout_active_i) |-> hopper_o == 2'h3; endproperty
  a_hopper: assert property (p_hopper) else $error("hopper not braked");
  property p_exit; s_exit |-> game_resume_o && !fault_msg_o ##1 !game_resume_o; endproperty
  a_exit: assert property (p_exit) else $error("bad resume at clear");
  property p_key; fault_flags_o[F_COIN_REVERSAL] && !attendant_key_i |=> fault_flags_o[F_COIN_REVERSAL]; endproperty
  a_key: assert property (p_key) else $error("reversal flag lost");
  property p_tech; fault_flags_o[F_PERIPHERAL] && !tech_clear_i |=> fault_flags_o[F_PERIPHERAL]; endproperty
  a_tech: assert property (p_tech) else $error("peripheral flag lost");
endmodule
`default_nettype wire

// ### test/sensor_model.sv
// Sensor side: coin path, hopper, reel and printer lines as event bits.
// Assumes its tasks are called right after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module sensor_model
  import lockup_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire hopper_cmd_t hopper_i,
  output logic [11:0] ev_o
);
  logic [11:0] ev = '0;
  logic coin;
  int gap = 3;
  int cnt;
  ////////////////////////////////////////
  // Hopper pays a coin every gap+1 cycles while payout is active, its motor runs and gap is nonzero
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt <= 0;
      coin <= 1'b0;
    end else begin
      cnt <= (cnt == 0) ? gap : cnt - 1;
      coin <= !hopper_i.motor_off && gap != 0 && cnt == 0;
    end
  end
  assign ev_o = {ev[11:6], ev[5] | (coin & ev[4]), ev[4:0]};
  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge clk_i);
    ev[k] <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic lvl(input int k, input logic v);
    ev[k] <= v;
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### test/machine_fault_lockup_controller_test.sv
// Self-checking bench for the lockup controller.
// Assumes package, design, checker and sensor model are compiled first.
`timescale 1ns/1ns
`default_nettype none
bind machine_fault_lockup_controller lockup_monitor #(.TICK_CYCLES(TICK_CYCLES), .PLAYER_INPUTS(PLAYER_INPUTS))
  i_lockup_monitor (.clk_i, .rst_i, .payout_active_i, .attendant_key_i, .tech_clear_i, .service_button_i,
  .player_en_o, .coin_accept_en_o, .service_o, .fault_msg_o, .alarm_o, .game_save_o, .game_resume_o,
  .reel_stop_o, .hopper_o, .lockup_o, .fault_flags_o);
module machine_fault_lockup_controller_test import lockup_pkg::*;;
  typedef struct {int sel; logic [31:0] exp;} note_t;
  note_t notes[$];
  logic clk_i = 1'b0, rst_i = 1'b1;
  logic [5:0] avs_address = '0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic attendant_key_i = 1'b0, door_open_i = 1'b0, tech_clear_i = 1'b0, game_saved_i = 1'b0, service_button_i = 1'b0;
  logic [7:0] player_allowed_i = '0;
  logic [31:0] avs_readdata;
  logic [31:0] rv[6] = '{32'h0, 32'h0A, 32'h7D0, 32'h1F4, 32'h05, 32'h0};
  logic [11:0] ev;
  logic [7:0] player_en_o;
  logic avs_waitrequest, coin_accept_en_o, service_o, fault_msg_o, info_msg_o, paper_low_msg_o, alarm_o;
  logic game_save_o, game_resume_o, resume_from_start_o, reel_stop_o, lockup_o;
  hopper_cmd_t hopper_o;
  logic [NUM_FAULTS-1:0] fault_flags_o;
  int err_total = 0;
  int comparisons = 0;
  int seed = 27035;
  int n_info = 0, n_resume = 0, res = 0, lim;
  always #4 clk_i = ~clk_i;
  machine_fault_lockup_controller #(.TICK_CYCLES(4), .PLAYER_INPUTS(8)) i_machine_fault_lockup_controller (
    .clk_i, .rst_i, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .coin_reversal_i(ev[0]), .coin_good_i(ev[1]), .coin_routed_i(ev[2]),
    .coin_misrouted_i(ev[3]), .payout_active_i(ev[4]), .hopper_coin_i(ev[5]), .hopper_blocked_i(ev[6]),
    .reel_stall_i(ev[7]), .reel_illegal_i(ev[8]), .periph_fail_i(ev[9]), .paper_low_i(ev[10]),
    .ticket_printed_i(ev[11]), .attendant_key_i, .door_open_i, .tech_clear_i, .game_saved_i, .player_allowed_i,
    .service_button_i, .player_en_o, .coin_accept_en_o, .service_o, .fault_msg_o, .info_msg_o, .paper_low_msg_o,
    .alarm_o, .game_save_o, .game_resume_o, .resume_from_start_o, .reel_stop_o, .hopper_o, .lockup_o,
    .fault_flags_o);
  sensor_model i_sensor_model (.clk_i, .rst_i, .hopper_i(hopper_o), .ev_o(ev));
  ////////////////////////////////////////
  function automatic logic [31:0] obs(input int s);
    case (s)
      0: return avs_readdata;
      1: return 32'(fault_flags_o);
      2: return 32'({lockup_o, fault_msg_o, reel_stop_o, game_save_o, coin_accept_en_o});
      3: return 32'(player_en_o);
      4: return 32'(hopper_o);
      5: return 32'(n_info);
      6: return 32'(n_resume);
      7: return 32'({paper_low_msg_o, resume_from_start_o});
      8: return 32'(alarm_o);
      10: return 32'(avs_waitrequest);
      default: return 32'(lockup_o);
    endcase
  endfunction
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      end_of_test();
    end
  endtask
  // Takes the oldest note when its result stands
  always @(negedge clk_i) begin
    note_t nt;
    if (info_msg_o === 1'b1) n_info++;
    if (game_resume_o === 1'b1) n_resume++;
    if (notes.size() > 0 && (notes[0].sel != 0 || (avs_read && avs_waitrequest === 1'b0))) begin
      nt = notes.pop_front();
      compare(obs(nt.sel), nt.exp);
    end
  end
  task automatic chk(input int s, input logic [31:0] e);
    notes.push_back(note_t'{s, e});
    @(posedge clk_i);
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    wait0(10, 50);
    {avs_read, avs_write} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int k);
    i_sensor_model.pulse(k);
  endtask
  task automatic lvl(input int k, input logic v);
    i_sensor_model.lvl(k, v);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    notes.push_back(note_t'{0, e});
    bus(1'b0, a, '0);
  endtask
  task automatic wait0(input int s, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (obs(s) !== '0 && n < lim);
    tmo(n, lim);
    @(posedge clk_i);
  endtask
  task automatic lock(input logic [9:0] f);
    player_allowed_i <= 8'($random(seed));
    service_button_i <= 1'($random(seed));
    repeat (3) @(posedge clk_i);
    chk(1, 32'(f));
    chk(2, 32'h1E);
    chk(3, '0);
    chk(8, 32'h1);
    game_saved_i <= 1'b1;
  endtask
  task automatic unlock(input int k, input bit w = 1'b1);
    {attendant_key_i, door_open_i, tech_clear_i} <= 3'(4 >> k);
    @(posedge clk_i);
    {attendant_key_i, door_open_i, tech_clear_i} <= 3'h0;
    if (!w) return;
    wait0(9, 50);
    res++;
    game_saved_i <= 1'b0;
    chk(2, 32'h01);
    chk(3, 32'(player_allowed_i));
    chk(6, res);
    wait0(8, 8000);
    chk(8, '0);
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) rd((i == 5) ? 6'h1C : 6'(i * 4), rv[i]);
    bus(1'b1, REG_MISROUTE_COUNT, 32'hFF);
    rd(REG_MISROUTE_COUNT, '0);
    lim = 2 + ($random(seed) & 3);
    bus(1'b1, REG_DIVERT_LIMIT, 32'(lim));
    avs_byteenable <= 4'hE;
    bus(1'b1, REG_DIVERT_LIMIT, 32'h1);
    avs_byteenable <= 4'hF;
    bus(1'b1, REG_HOPPER_TIMEOUT, {16'($random(seed)), 16'h0008});
    rd(REG_HOPPER_TIMEOUT, 32'h8);
    bus(1'b1, REG_JAM_TIME, 32'h3);
    bus(1'b1, REG_TICKET_LIMIT, 32'h2);
    pulse(0);
    repeat (2) @(posedge clk_i);
    chk(5, 1);
    chk(1, 0);
    pulse(1);
    pulse(0);
    pulse(0);
    lock(10'h001);
    unlock(0);
    lvl(4, 1'b1);
    repeat (10) @(posedge clk_i);
    pulse(7);
    pulse(8);
    lock(10'h0C0);
    chk(4, 32'h3);
    lvl(4, 1'b0);
    unlock(1);
    pulse(9);
    lock(10'h100);
    unlock(1, 1'b0);
    chk(1, 32'h100);
    unlock(2);
    repeat (lim - 1) pulse(3);
    chk(1, 0);
    pulse(3);
    lock(10'h002);
    pulse(2);
    unlock(3);
    i_sensor_model.gap = 0;
    lvl(4, 1'b1);
    repeat (60) @(posedge clk_i);
    lock(10'h004);
    lvl(4, 1'b0);
    unlock(1);
    lvl(6, 1'b1);
    repeat (20) @(posedge clk_i);
    lvl(6, 1'b0);
    lock(10'h008);
    unlock(1);
    i_sensor_model.gap = 3;
    lvl(4, 1'b1);
    repeat (10) @(posedge clk_i);
    lvl(4, 1'b0);
    pulse(5);
    lock(10'h010);
    pulse(5);
    chk(1, 32'h030);
    unlock(1);
    bus(1'b1, REG_CTRL, 32'h2);
    lvl(10, 1'b1);
    pulse(11);
    chk(1, 0);
    chk(7, 32'h1);
    pulse(11);
    lock(10'h200);
    lvl(10, 1'b0);
    unlock(3);
    bus(1'b1, REG_CTRL, 32'h3);
    lvl(10, 1'b1);
    repeat (3) pulse(11);
    chk(7, 32'h3);
    chk(9, 0);
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    tmo(1, 1);
  end
endmodule
`default_nettype wire
